// >>> include/fsc_pkg.sv
// Package: constants and types for the fan speed controller
package fsc_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned NUM_FANS = 4;
  localparam int unsigned NUM_SETPOINTS = 5;
  // Time units
  localparam int unsigned TACH_WINDOW_MS = 1000;
  localparam int unsigned FAST_CHECK_MS = 250;
  localparam int unsigned SLOW_CHECK_MS = 1000;
  localparam int unsigned TACH_WINDOW_CYC = CLK_HZ / 1000 * TACH_WINDOW_MS;
  localparam int unsigned FAST_CHECK_CYC = CLK_HZ / 1000 * FAST_CHECK_MS;
  localparam int unsigned SLOW_CHECK_CYC = CLK_HZ / 1000 * SLOW_CHECK_MS;
  localparam int unsigned RPM_PER_RPS = 60;
  localparam int unsigned DUTY_FULL = 100;
  // Register map, byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_TEMP = 8'h08;
  localparam logic [7:0] ADDR_OVERTEMP = 8'h0c;
  localparam logic [7:0] ADDR_HYST = 8'h10;
  localparam logic [7:0] ADDR_SP_BASE = 8'h20;
  localparam logic [7:0] ADDR_FAN_BASE = 8'h40;
  localparam logic [7:0] ADDR_SPEED_BASE = 8'h60;
  localparam logic [7:0] ADDR_DIV_BASE = 8'h80;
  // Control register fields
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_FAST_BIT = 2;
  localparam int unsigned CTRL_POL_BIT = 3;
  localparam int unsigned CTRL_RAMP_LSB = 8;
  localparam logic [31:0] CTRL_RESET = 32'h00000a00;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    FSC_MODE_CMD, FSC_MODE_HYST, FSC_MODE_SETPT, FSC_MODE_RSVD
  } fsc_mode_type;
endpackage : fsc_pkg

// >>> src/fsc_top.sv
// Fan speed controller: four fan drives, tach counters, AXI4-Lite registers
// What this block does
// - Four fans, each with tachometer input
// - Per-fan pulses per revolution configured
// - Alarm when speed below fault threshold
// - Duty settable 0 to 100 in 1% steps
// - Drive frequency configurable per fan
// - Count tach transitions each one second
// - Speed readable by host in RPM
// - Duty follows host command unless algorithm
// - Calibration duties (on, off, maximum) stored, manual entry
// - Setpoint algorithm works over measured speed range
// - Hysteretic: on at upper, off below lower
// - Hysteretic starts off, checks 1s or 250ms
// - Over-temperature declares fault and responds
// - Five set points of temperature and speed
// - Rising temperature raises target and ramps duty
// - Falling: drop target only below setpoint temp
// - Ramp at selectable rate; jump to on duty
// - Setpoint starts off, samples 250ms or 1s
// - Control active only while fans-installed asserted
`timescale 1ns/1ps
`default_nettype none
module fsc_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] fan_tach,
  input wire logic fans_installed,
  output logic [3:0] fast_pulse_output,
  output logic overtemp_fault
);
  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [6:0] clamp_duty(input logic [7:0] d);
    if (d > 8'(fsc_pkg::DUTY_FULL)) begin
      return 7'(fsc_pkg::DUTY_FULL);
    end
    return d[6:0];
  endfunction : clamp_duty

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_ff;
  logic [15:0] temp_ff;
  logic [15:0] overtemp_limit_ff;
  logic [31:0] hyst_ff;
  logic [31:0] sp_ff [5];
  logic [31:0] fan_cfg_ff [4];
  logic [31:0] cal_ff [4];
  logic [23:0] div_ff [4];
  logic [15:0] rpm_ff [4];
  logic [3:0] alarm_ff;
  logic aw_ok_ff, w_ok_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;

  fsc_pkg::fsc_mode_type mode;
  logic fast_check, active;
  logic [7:0] ramp_rate;
  assign mode = fsc_pkg::fsc_mode_type'(ctrl_ff[fsc_pkg::CTRL_MODE_LSB +: 2]);
  assign fast_check = ctrl_ff[fsc_pkg::CTRL_FAST_BIT];
  assign ramp_rate = ctrl_ff[fsc_pkg::CTRL_RAMP_LSB +: 8];
  // Installed indicator at its configured polarity
  assign active = fans_installed ^ ctrl_ff[fsc_pkg::CTRL_POL_BIT];

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  logic wr_go;
  assign wr_go = aw_ok_ff && w_ok_ff && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_ff <= 1'b0;
      w_ok_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= fsc_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_ok_ff && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_ok_ff && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_ok_ff <= 1'b0;
        w_ok_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_ff == fsc_pkg::ADDR_STATUS ||
            awaddr_ff[7:4] == fsc_pkg::ADDR_SPEED_BASE[7:4] ||
            awaddr_ff > 8'h8c) ? fsc_pkg::RESP_SLVERR : fsc_pkg::RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Configuration stores; calibration data entered by hand here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= fsc_pkg::CTRL_RESET;
      temp_ff <= 16'h0000;
      overtemp_limit_ff <= 16'hffff;
      hyst_ff <= 32'h00000000;
      for (int i = 0; i < 5; i++) begin
        sp_ff[i] <= 32'h00000000;
      end
      for (int i = 0; i < 4; i++) begin
        fan_cfg_ff[i] <= 32'h00000100;
        cal_ff[i] <= 32'h00000000;
        div_ff[i] <= 24'h000002;
      end
    end else if (wr_go) begin
      case (awaddr_ff)
        fsc_pkg::ADDR_CTRL: ctrl_ff <= merge(ctrl_ff, wdata_ff, wstrb_ff);
        fsc_pkg::ADDR_TEMP: temp_ff <= wdata_ff[15:0];
        fsc_pkg::ADDR_OVERTEMP: overtemp_limit_ff <= wdata_ff[15:0];
        fsc_pkg::ADDR_HYST: hyst_ff <= merge(hyst_ff, wdata_ff, wstrb_ff);
        default: begin
          for (int i = 0; i < 5; i++) begin
            if (awaddr_ff == fsc_pkg::ADDR_SP_BASE + 8'(4*i)) begin
              sp_ff[i] <= merge(sp_ff[i], wdata_ff, wstrb_ff);
            end
          end
          for (int i = 0; i < 4; i++) begin
            // Word: [6:0] command duty, [11:8] pulses/rev, [31:16] fault rpm
            if (awaddr_ff == fsc_pkg::ADDR_FAN_BASE + 8'(8*i)) begin
              fan_cfg_ff[i] <= merge(fan_cfg_ff[i], wdata_ff, wstrb_ff);
            end
            // Word: [6:0] on duty, [14:8] off duty, [22:16] maximum duty
            if (awaddr_ff == fsc_pkg::ADDR_FAN_BASE + 8'(8*i+4)) begin
              cal_ff[i] <= merge(cal_ff[i], wdata_ff, wstrb_ff);
            end
            if (awaddr_ff == fsc_pkg::ADDR_DIV_BASE + 8'(4*i)) begin
              div_ff[i] <= wdata_ff[23:0];
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  logic [31:0] rd_val;
  logic rd_err;
  always_comb begin
    logic [7:0] a;
    a = s_axi_araddr[7:0];
    rd_val = 32'h00000000;
    rd_err = 1'b0;
    case (a)
      fsc_pkg::ADDR_CTRL: rd_val = ctrl_ff;
      fsc_pkg::ADDR_STATUS: rd_val = {27'h0, overtemp_fault, alarm_ff};
      fsc_pkg::ADDR_TEMP: rd_val = {16'h0, temp_ff};
      fsc_pkg::ADDR_OVERTEMP: rd_val = {16'h0, overtemp_limit_ff};
      fsc_pkg::ADDR_HYST: rd_val = hyst_ff;
      default: begin
        rd_err = 1'b1;
        for (int i = 0; i < 5; i++) begin
          if (a == fsc_pkg::ADDR_SP_BASE + 8'(4*i)) begin
            rd_val = sp_ff[i];
            rd_err = 1'b0;
          end
        end
        for (int i = 0; i < 4; i++) begin
          if (a == fsc_pkg::ADDR_FAN_BASE + 8'(8*i)) begin
            rd_val = fan_cfg_ff[i];
            rd_err = 1'b0;
          end
          if (a == fsc_pkg::ADDR_FAN_BASE + 8'(8*i+4)) begin
            rd_val = cal_ff[i];
            rd_err = 1'b0;
          end
          if (a == fsc_pkg::ADDR_SPEED_BASE + 8'(4*i)) begin
            rd_val = {16'h0, rpm_ff[i]};
            rd_err = 1'b0;
          end
          if (a == fsc_pkg::ADDR_DIV_BASE + 8'(4*i)) begin
            rd_val = {8'h0, div_ff[i]};
            rd_err = 1'b0;
          end
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= fsc_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_err ? fsc_pkg::RESP_SLVERR : fsc_pkg::RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Tachometer: transitions per second, converted to RPM
  // ----------------------------------------------------------------
  logic [25:0] sec_cnt_ff;
  logic sec_tick;
  logic [3:0] tach_d_ff;
  logic [15:0] edge_cnt_ff [4];
  assign sec_tick = sec_cnt_ff == 26'(fsc_pkg::TACH_WINDOW_CYC - 1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sec_cnt_ff <= 26'h0000000;
    end else begin
      sec_cnt_ff <= sec_tick ? 26'h0000000 : sec_cnt_ff + 26'h0000001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Idle level of a pulled-up tach, so reset makes no false edge
      tach_d_ff <= 4'hf;
      alarm_ff <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        edge_cnt_ff[i] <= 16'h0000;
        rpm_ff[i] <= 16'h0000;
      end
    end else begin
      tach_d_ff <= fan_tach;
      for (int i = 0; i < 4; i++) begin
        logic [15:0] hit;
        logic [3:0] ppr;
        logic [21:0] rpm;
        hit = (fan_tach[i] != tach_d_ff[i]) ? 16'h0001 : 16'h0000;
        ppr = (fan_cfg_ff[i][11:8] == 4'h0) ? 4'h1 : fan_cfg_ff[i][11:8];
        // Two transitions per tach pulse
        rpm = 22'((32'(edge_cnt_ff[i] + hit) * fsc_pkg::RPM_PER_RPS)
            / (32'(ppr) * 32'd2));
        if (sec_tick) begin
          edge_cnt_ff[i] <= 16'h0000;
          rpm_ff[i] <= (rpm > 22'h00ffff) ? 16'hffff : rpm[15:0];
          alarm_ff[i] <= rpm < 22'(fan_cfg_ff[i][31:16]);
        end else if (edge_cnt_ff[i] != 16'hffff) begin
          edge_cnt_ff[i] <= edge_cnt_ff[i] + hit;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Temperature algorithms
  // ----------------------------------------------------------------
  logic [25:0] chk_cnt_ff;
  logic chk_tick;
  logic [25:0] chk_len;
  assign chk_len = fast_check ? 26'(fsc_pkg::FAST_CHECK_CYC - 1)
      : 26'(fsc_pkg::SLOW_CHECK_CYC - 1);
  assign chk_tick = chk_cnt_ff >= chk_len;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chk_cnt_ff <= 26'h0000000;
    end else begin
      chk_cnt_ff <= chk_tick ? 26'h0000000 : chk_cnt_ff + 26'h0000001;
    end
  end

  logic hyst_on_ff;
  logic [15:0] target_ff;
  logic [2:0] level_ff;
  logic [6:0] duty_ff [4];
  logic [6:0] ramp_acc_ff;

  // Highest setpoint whose temperature is exceeded
  logic [2:0] above;
  always_comb begin
    above = 3'd0;
    for (int k = 0; k < 5; k++) begin
      if (temp_ff > sp_ff[k][15:0]) begin
        above = 3'(k + 1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hyst_on_ff <= 1'b0;
      overtemp_fault <= 1'b0;
      level_ff <= 3'd0;
      target_ff <= 16'h0000;
    end else if (chk_tick) begin
      overtemp_fault <= temp_ff > overtemp_limit_ff;
      if (temp_ff >= hyst_ff[15:0]) begin
        hyst_on_ff <= 1'b1;
      end else if (temp_ff < hyst_ff[31:16]) begin
        hyst_on_ff <= 1'b0;
      end
      // Rise immediately, fall only past the lower setpoint temperature
      if (above > level_ff || above + 3'd1 < level_ff ||
          (above < level_ff && temp_ff < sp_ff[level_ff-3'd1][15:0])) begin
        level_ff <= above;
        target_ff <= (above == 3'd0) ? 16'h0000
            : sp_ff[above-3'd1][31:16];
      end
    end
  end

  // Ramp step per check so that the per-second rate is met
  logic [6:0] step;
  assign step = fast_check ? 7'((8'(ramp_rate[6:0]) + 8'd3) >> 2)
      : ramp_rate[6:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ramp_acc_ff <= 7'h00;
      for (int i = 0; i < 4; i++) begin
        duty_ff[i] <= 7'h00;
      end
    end else begin
      ramp_acc_ff <= step;
      for (int i = 0; i < 4; i++) begin
        logic [6:0] on_d, off_d, max_d;
        on_d = clamp_duty({1'b0, cal_ff[i][6:0]});
        off_d = clamp_duty({1'b0, cal_ff[i][14:8]});
        max_d = clamp_duty({1'b0, cal_ff[i][22:16]});
        if (!active) begin
          duty_ff[i] <= 7'h00;
        end else if (overtemp_fault) begin
          duty_ff[i] <= 7'(fsc_pkg::DUTY_FULL);
        end else begin
          case (mode)
            fsc_pkg::FSC_MODE_HYST: duty_ff[i] <= hyst_on_ff
                ? 7'(fsc_pkg::DUTY_FULL) : 7'h00;
            fsc_pkg::FSC_MODE_SETPT: begin
              if (chk_tick) begin
                if (target_ff == 16'h0000) begin
                  duty_ff[i] <= (8'(duty_ff[i])
                      > 8'(off_d) + 8'(ramp_acc_ff))
                      ? duty_ff[i] - ramp_acc_ff : 7'h00;
                end else if (duty_ff[i] < on_d) begin
                  duty_ff[i] <= on_d;
                end else if (rpm_ff[i] < target_ff) begin
                  // Ceiling is the calibrated maximum duty
                  duty_ff[i] <= clamp_duty(8'(duty_ff[i] + ramp_acc_ff)
                      > 8'(max_d) ? 8'(max_d)
                      : 8'(duty_ff[i] + ramp_acc_ff));
                end else if (rpm_ff[i] > target_ff) begin
                  duty_ff[i] <= (8'(duty_ff[i])
                      > 8'(on_d) + 8'(ramp_acc_ff))
                      ? duty_ff[i] - ramp_acc_ff : on_d;
                end
              end
            end
            default: duty_ff[i] <= clamp_duty({1'b0,
                fan_cfg_ff[i][6:0]});
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Pulse generators, 100 slots per period
  // ----------------------------------------------------------------
  logic [23:0] pre_ff [4];
  logic [6:0] slot_ff [4];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fast_pulse_output <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        pre_ff[i] <= 24'h000000;
        slot_ff[i] <= 7'h00;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (pre_ff[i] >= div_ff[i] - 24'h000001) begin
          pre_ff[i] <= 24'h000000;
          slot_ff[i] <= (slot_ff[i] == 7'(fsc_pkg::DUTY_FULL - 1))
              ? 7'h00 : slot_ff[i] + 7'h01;
        end else begin
          pre_ff[i] <= pre_ff[i] + 24'h000001;
        end
        fast_pulse_output[i] <= slot_ff[i] < duty_ff[i];
      end
    end
  end
endmodule : fsc_top
`default_nettype wire

// >>> verification/fsc_fan_model.sv
// Behavioural cooling fan: spins while driven, tach toggles as it turns
`timescale 1ns/1ps
`default_nettype none
module fsc_fan_model #(
  parameter int HALF_REV = 37,
  parameter int SPIN_DOWN = 600
) (
  input wire logic aclk,
  input wire logic drive,
  output logic tach
);
  int idle_cnt;
  int phase_cnt;
  initial begin
    idle_cnt = SPIN_DOWN;
    phase_cnt = 0;
    tach = 1'b1;
  end
  // Inertia keeps the rotor turning for SPIN_DOWN cycles after the drive drops
  always @(posedge aclk) begin
    if (drive) begin
      idle_cnt <= 0;
    end else if (idle_cnt < SPIN_DOWN) begin
      idle_cnt <= idle_cnt + 1;
    end
    if (idle_cnt < SPIN_DOWN) begin
      phase_cnt <= (phase_cnt == HALF_REV - 1) ? 0 : phase_cnt + 1;
      if (phase_cnt == HALF_REV - 1) tach <= ~tach;
    end else begin
      // Open-collector tach with pull-up: a stopped fan rests high
      tach <= 1'b1;
    end
  end
endmodule : fsc_fan_model
`default_nettype wire

// >>> verification/fsc_top_properties.sv
// Checker: bus handshake and drive-output properties of fsc_top
`timescale 1ns/1ps
`default_nettype none
module fsc_top_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] fast_pulse_output,
  input wire logic overtemp_fault
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  a_reset_quiet: assert property ($rose(aresetn) |->
    fast_pulse_output == 4'h0 && !overtemp_fault && !s_axi_rvalid)
    else $error("outputs not clear after reset");
  a_aw_cause: assert property (s_axi_awready |-> s_axi_awvalid)
    else $error("awready without awvalid");
  a_ar_cause: assert property (s_axi_arready |-> s_axi_arvalid)
    else $error("arready without arvalid");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready
    |-> ##[1:4] s_axi_bvalid) else $error("write answer late");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
  a_hole_read: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr[7:0] == 8'h14 |=> s_axi_rresp == fsc_pkg::RESP_SLVERR
    && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
  a_ro_write: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_awaddr[7:0] == fsc_pkg::ADDR_STATUS |-> ##[1:4]
    (s_axi_bvalid && s_axi_bresp == fsc_pkg::RESP_SLVERR))
    else $error("status write not refused");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_drive: cover property ($rose(fast_pulse_output[0]));
endmodule : fsc_top_checker
bind fsc_top fsc_top_checker u_fsc_top_checker (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .fast_pulse_output(fast_pulse_output), .overtemp_fault(overtemp_fault)
);
`default_nettype wire

// >>> verification/fsc_top_tb.sv
// Testbench: registers, refusals, fan drive duty, gating and modes
`timescale 1ns/1ps
`default_nettype none
module fsc_top_tb;
  logic aclk, aresetn, installed, fault;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] awaddr, wdata, araddr, rdata, d;
  logic [3:0] wstrb, pwm;
  logic [1:0] bresp, rresp;
  wire logic [3:0] tach;
  int errors, cmp_count;
  int duty [4];
  int tbl [8] = '{0, 1, 100, 99, 100, 0, 50, 1};
  logic [31:0] mdl [logic [7:0]];

  fsc_top u_fsc_top (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .fan_tach(tach),
    .fans_installed(installed), .fast_pulse_output(pwm),
    .overtemp_fault(fault)
  );
  for (genvar g = 0; g < 4; g++) begin : g_fan
    fsc_fan_model u_fsc_fan_model (.aclk(aclk), .drive(pwm[g]),
      .tach(tach[g]));
  end

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // Ready is raised after a random stall so held answers are exercised
  task automatic wreg(input logic [7:0] a, input logic [31:0] v,
                      input logic [3:0] s, input logic [1:0] er);
    int n;
    int st;
    n = 0;
    st = $urandom_range(0, 3);
    @(posedge aclk);
    awaddr <= {24'h0, a};
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (n == st) bready <= 1'b1;
    end while (!(bready && bvalid) && ++n < 300);
    chk("bresp", bresp, er);
    bready <= 1'b0;
    if (er == fsc_pkg::RESP_OKAY) begin
      for (int b = 0; b < 4; b++) if (s[b]) mdl[a][8*b +: 8] = v[8*b +: 8];
    end
  endtask : wreg

  task automatic creg(input logic [7:0] a, input logic [1:0] er);
    int n;
    int st;
    n = 0;
    st = $urandom_range(0, 3);
    @(posedge aclk);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (n == st) rready <= 1'b1;
    end while (!(rready && rvalid) && ++n < 300);
    chk("rresp", rresp, er);
    chk("rdata", rdata, (er == fsc_pkg::RESP_OKAY) ? mdl[a] : 32'h0);
    rready <= 1'b0;
  endtask : creg

  // Divider 10 gives a 1000-cycle period with 10*duty cycles high
  task automatic measure(input logic on);
    int hi [4];
    hi = '{default: 0};
    repeat (1000) @(posedge aclk);
    repeat (1000) begin
      @(posedge aclk);
      for (int i = 0; i < 4; i++) hi[i] += pwm[i];
    end
    for (int i = 0; i < 4; i++)
      chk("pwm_high", hi[i], on ? 10 * duty[i] : 0);
    $display("test drive on=%0d done", on);
  endtask : measure

  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (60000) @(posedge aclk);
    errors++;
    conclude();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    aresetn = 1'b0;
    installed = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, wdata, araddr, wstrb} = '0;
    void'($urandom(73522));
    mdl[fsc_pkg::ADDR_CTRL] = fsc_pkg::CTRL_RESET;
    mdl[fsc_pkg::ADDR_STATUS] = 32'h0;
    mdl[fsc_pkg::ADDR_OVERTEMP] = 32'h0000ffff;
    for (int i = 0; i < 4; i++) begin
      mdl[fsc_pkg::ADDR_FAN_BASE + 8'(8 * i)] = 32'h00000100;
      mdl[fsc_pkg::ADDR_SPEED_BASE + 8'(4 * i)] = 32'h0;
    end
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (mdl[a]) creg(a, fsc_pkg::RESP_OKAY);
    $display("test reset values done");
    for (int k = 0; k < 5; k++) begin
      d = $urandom;
      // Zero speed on the first set point lets the fan stop when cool
      if (k == 0) d[31:16] = 16'h0;
      wreg(fsc_pkg::ADDR_SP_BASE + 8'(4 * k), d, 4'hf, 2'b00);
    end
    for (int i = 0; i < 4; i++) begin
      d = ($urandom & 32'hffff0e00) | 32'h100 | 32'($urandom_range(0, 100));
      wreg(fsc_pkg::ADDR_FAN_BASE + 8'(8 * i), d, 4'hf, 2'b00);
      d = $urandom & 32'h003f3f3f;
      wreg(fsc_pkg::ADDR_FAN_BASE + 8'(8 * i + 4), d, 4'hf, 2'b00);
      // Four-wire fan control input run at 40 kHz
      wreg(fsc_pkg::ADDR_DIV_BASE + 8'(4 * i), 32'ha, 4'hf, 2'b00);
    end
    d = {16'($urandom_range(0, 199)), 16'($urandom_range(200, 999))};
    wreg(fsc_pkg::ADDR_HYST, d, 4'hf, 2'b00);
    wreg(fsc_pkg::ADDR_TEMP, 32'($urandom_range(0, 150)), 4'hf, 2'b00);
    wreg(fsc_pkg::ADDR_CTRL, 32'hffff14ff, 4'b0010, 2'b00);
    wreg(fsc_pkg::ADDR_STATUS, $urandom, 4'hf, fsc_pkg::RESP_SLVERR);
    wreg(fsc_pkg::ADDR_SPEED_BASE, $urandom, 4'hf, 2'b10);
    wreg(8'h90, $urandom, 4'hf, fsc_pkg::RESP_SLVERR);
    creg(8'h14, fsc_pkg::RESP_SLVERR);
    foreach (mdl[a]) creg(a, fsc_pkg::RESP_OKAY);
    $display("test registers done");
    for (int r = 0; r < 3; r++) begin
      for (int i = 0; i < 4; i++) begin
        duty[i] = (r < 2) ? tbl[4 * r + i] : $urandom_range(0, 100);
        d = 32'h100 | 32'(duty[i]);
        wreg(fsc_pkg::ADDR_FAN_BASE + 8'(8 * i), d, 4'hf, 2'b00);
      end
      measure(1'b1);
    end
    installed <= 1'b0;
    measure(1'b0);
    wreg(fsc_pkg::ADDR_CTRL, 32'h00001408, 4'hf, 2'b00);
    measure(1'b1);
    installed <= 1'b1;
    measure(1'b0);
    for (int m = 1; m < 3; m++) begin
      d = 32'h1400 | 32'(m) | ((m == 2) ? 32'h4 : 32'h0);
      wreg(fsc_pkg::ADDR_CTRL, d, 4'hf, 2'b00);
      measure(1'b0);
    end
    wreg(fsc_pkg::ADDR_CTRL, 32'h1400, 4'hf, 2'b00);
    measure(1'b1);
    // Fans spin but no full counting interval has elapsed yet
    foreach (mdl[a]) creg(a, fsc_pkg::RESP_OKAY);
    chk("fault", {31'h0, fault}, 32'h0);
    $display("test final readback done");
    conclude();
  end
endmodule : fsc_top_tb
`default_nettype wire
